/* controller_mode_fsm.v */
// Purpose: Operating-mode state machine of a programmable controller
// Assumes: Key switch contacts arrive raw; host inputs are on ref_clk_in
// Notes: A key switch change wins over a host request in the same cycle
// Operation
// [RULE1] Key switch position restricts which modes may be active.
// [RULE2] Run position refuses edits, downloads, firmware updates and host mode changes.
// [RULE3] Remote Run executes, logic drives outputs, allows edits and host changes.
// [RULE4] Remote Program stops tasks, fallback outputs, allows downloads, edits, changes.
// [RULE5] Remote Test executes, fallback outputs, allows edits, changes; no downloads.
// [RULE6] Program stops tasks and logic outputs; edits, downloads, peer data allowed.
// [RULE7] Fallback puts each output module to its own on, off or hold choice.
// [RULE8] Program position ignores host mode-change requests.
// [RULE9] Run to remote position enters Remote Run.
// [RULE10] Program to remote position enters Remote Program.
// [RULE11] Remote Test never entered by switch movement alone.
// [RULE12] Host requests honoured only online with switch at remote.
// [RULE13] Host offers different mode choices depending on switch position.
// [RULE14] Operators should keep switch at run during production.
// [RULE15] Switch synchronised and debounced; mode changes only on stable change or request.
`timescale 1ns/1ps
`include "mode_defines.vh"

module controller_mode_fsm #(
   parameter [`DEB_CNT_W-1:0] DEB_CYCLES = `DEBOUNCE_CYCLES
) (
   input wire ref_clk_in,
   input wire srst_in,
   input wire key_run_in,
   input wire key_remote_in,
   input wire key_program_in,
   input wire host_online_in,
   input wire host_req_valid_in,
   input wire [1:0] host_req_mode_in,
   input wire [`NUM_OUT-1:0] logic_out_in,
   input wire [2*`NUM_OUT-1:0] fallback_cfg_in,
   output wire host_req_ack_out,
   output wire host_req_nak_out,
   output reg [2:0] mode_out,
   output reg [1:0] switch_pos_out,
   output reg task_exec_out,
   output reg outputs_live_out,
   output reg edit_permit_out,
   output reg download_permit_out,
   output reg fw_update_permit_out,
   output reg host_mode_permit_out,
   output reg msg_send_permit_out,
   output reg peer_data_permit_out,
   output reg net_sched_permit_out,
   output reg [`NUM_OUT-1:0] out_drive_out
);

   localparam ST_RUN = `MODE_RUN;
   localparam ST_REM_RUN = `MODE_REM_RUN;
   localparam ST_REM_PROGRAM_POSITION = `MODE_REM_PROGRAM_POSITION;
   localparam ST_REM_TEST = `MODE_REM_TEST;
   localparam ST_PROGRAM = `MODE_PROGRAM;

   wire [1:0] pos;
   wire pos_valid;
   wire pos_change;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`NUM_OUT-1:0] hold_r;
   reg req_ok;
   integer i;

   // [RULE15] Synchronise and debounce key
   switch_debounce #(
      .DEB_CYCLES(DEB_CYCLES)
   ) u_deb (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .key_run_in(key_run_in),
      .key_remote_in(key_remote_in),
      .key_program_in(key_program_in),
      .pos_out(pos),
      .pos_valid_out(pos_valid),
      .pos_change_out(pos_change)
   );

   // Map a host request code to a mode
   function [2:0] req_to_mode;
      input [1:0] req;
      begin
         case (req)
            `REQ_REM_PROGRAM_POSITION: req_to_mode = ST_REM_PROGRAM_POSITION;
            `REQ_REM_RUN: req_to_mode = ST_REM_RUN;
            default: req_to_mode = ST_REM_TEST;
         endcase
      end
   endfunction

   // Fallback level for one output module
   function fallback_bit;
      input [1:0] cfg;
      input held;
      begin
         case (cfg)
            `FB_ON: fallback_bit = 1'b1;
            `FB_HOLD: fallback_bit = held;
            default: fallback_bit = 1'b0;
         endcase
      end
   endfunction

   // Modes whose outputs follow logic
   function drives_live;
      input [2:0] st;
      begin
         drives_live = (st == ST_RUN) || (st == ST_REM_RUN);
      end
   endfunction

   // [RULE12] Host request gating
   // [RULE2] Refused at run position
   // [RULE8] Ignored at program position
   always @* begin
      req_ok = host_req_valid_in && host_online_in && pos_valid && !pos_change &&
               (pos == `SW_REMOTE) && (host_req_mode_in != `REQ_INVALID);
   end

   assign host_req_ack_out = req_ok;
   assign host_req_nak_out = host_req_valid_in && !req_ok;

   // Next mode selection
   always @* begin
      state_nxt = state_r;
      if (pos_change) begin
         case (pos)
            // [RULE1] Position restricts mode
            `SW_RUN: state_nxt = ST_RUN;
            `SW_PROGRAM: state_nxt = ST_PROGRAM;
            `SW_REMOTE: begin
               // [RULE9] Run to remote
               if (state_r == ST_RUN)
                  state_nxt = ST_REM_RUN;
               // [RULE10] Program to remote
               // [RULE11] Never Remote Test by switch
               else
                  state_nxt = ST_REM_PROGRAM_POSITION;
            end
            default: state_nxt = state_r;
         endcase
      end else if (req_ok) begin
         // [RULE12] Accepted host request
         state_nxt = req_to_mode(host_req_mode_in);
      end
   end

   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_r <= ST_PROGRAM;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Hold-last-value capture while logic drives outputs
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         hold_r <= {`NUM_OUT{1'b0}};
      end else if (drives_live(state_r)) begin
         hold_r <= logic_out_in;
      end
   end

   // Mode permissions and output drive
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         mode_out <= ST_PROGRAM;
         switch_pos_out <= `SW_INVALID;
         task_exec_out <= 1'b0;
         outputs_live_out <= 1'b0;
         edit_permit_out <= 1'b0;
         download_permit_out <= 1'b0;
         fw_update_permit_out <= 1'b0;
         host_mode_permit_out <= 1'b0;
         msg_send_permit_out <= 1'b0;
         peer_data_permit_out <= 1'b0;
         net_sched_permit_out <= 1'b0;
         out_drive_out <= {`NUM_OUT{1'b0}};
      end else begin
         mode_out <= state_r;
         switch_pos_out <= pos;
         host_mode_permit_out <= pos_valid && (pos == `SW_REMOTE) && host_online_in;
         peer_data_permit_out <= 1'b1;
         case (state_r)
            ST_RUN: begin
               // [RULE2] Run locks editing
               task_exec_out <= 1'b1;
               outputs_live_out <= 1'b1;
               edit_permit_out <= 1'b0;
               download_permit_out <= 1'b0;
               fw_update_permit_out <= 1'b0;
               msg_send_permit_out <= 1'b1;
               net_sched_permit_out <= 1'b0;
            end
            ST_REM_RUN: begin
               // [RULE3] Remote Run permissions
               task_exec_out <= 1'b1;
               outputs_live_out <= 1'b1;
               edit_permit_out <= 1'b1;
               download_permit_out <= 1'b0;
               fw_update_permit_out <= 1'b0;
               msg_send_permit_out <= 1'b1;
               net_sched_permit_out <= 1'b0;
            end
            ST_REM_PROGRAM_POSITION: begin
               // [RULE4] Remote Program permissions
               task_exec_out <= 1'b0;
               outputs_live_out <= 1'b0;
               edit_permit_out <= 1'b1;
               download_permit_out <= 1'b1;
               fw_update_permit_out <= 1'b1;
               msg_send_permit_out <= 1'b0;
               net_sched_permit_out <= 1'b1;
            end
            ST_REM_TEST: begin
               // [RULE5] Remote Test permissions
               task_exec_out <= 1'b1;
               outputs_live_out <= 1'b0;
               edit_permit_out <= 1'b1;
               download_permit_out <= 1'b0;
               fw_update_permit_out <= 1'b0;
               msg_send_permit_out <= 1'b0;
               net_sched_permit_out <= 1'b0;
            end
            default: begin
               // [RULE6] Program mode permissions
               task_exec_out <= 1'b0;
               outputs_live_out <= 1'b0;
               edit_permit_out <= 1'b1;
               download_permit_out <= 1'b1;
               fw_update_permit_out <= 1'b1;
               msg_send_permit_out <= 1'b0;
               net_sched_permit_out <= 1'b1;
            end
         endcase
         // [RULE7] Per-module fallback drive
         for (i = 0; i < `NUM_OUT; i = i + 1) begin
            if (drives_live(state_r))
               out_drive_out[i] <= logic_out_in[i];
            else
               out_drive_out[i] <= fallback_bit(fallback_cfg_in[2*i +: 2], hold_r[i]);
         end
      end
   end

endmodule

/* controller_mode_fsm_assertions.sv */
// Purpose: Port checker for the mode state machine
// Assumes: Only top ports visible
// Notes: Bound at the foot
`timescale 1ns/1ps
`include "mode_defines.vh"
module mode_fsm_chk #(
   parameter [`DEB_CNT_W-1:0] DEB_CYCLES = `DEBOUNCE_CYCLES
) (
   input wire ref_clk_in,
   input wire srst_in,
   input wire key_run_in,
   input wire key_remote_in,
   input wire key_program_in,
   input wire host_online_in,
   input wire host_req_valid_in,
   input wire [1:0] host_req_mode_in,
   input wire [`NUM_OUT-1:0] logic_out_in,
   input wire [2*`NUM_OUT-1:0] fallback_cfg_in,
   input wire host_req_ack_out,
   input wire [2:0] mode_out,
   input wire [1:0] switch_pos_out,
   input wire task_exec_out,
   input wire outputs_live_out,
   input wire download_permit_out,
   input wire [`NUM_OUT-1:0] out_drive_out
);
   reg [2:0] keys_r;
   reg [`DEB_CNT_W-1:0] still_r;
   wire [2:0] keys = {key_run_in, key_remote_in, key_program_in};
   wire [2:0] tgt = (host_req_mode_in == `REQ_REM_PROGRAM_POSITION) ? `MODE_REM_PROGRAM_POSITION :
      (host_req_mode_in == `REQ_REM_RUN) ? `MODE_REM_RUN : `MODE_REM_TEST;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // Contact stability count
   always @(posedge ref_clk_in) begin
      keys_r <= keys;
      if (srst_in || keys != keys_r)
         still_r <= {`DEB_CNT_W{1'b0}};
      else if (!(&still_r))
         still_r <= still_r + 1'b1;
   end
   function fb_ok(input [2*`NUM_OUT-1:0] c, input [`NUM_OUT-1:0] d);
      integer i;
      begin
         fb_ok = 1'b1;
         for (i = 0; i < `NUM_OUT; i = i + 1) begin
            if (c[2*i+:2] == `FB_ON && !d[i])
               fb_ok = 1'b0;
            if (c[2*i+:2] != `FB_ON && c[2*i+:2] != `FB_HOLD && d[i])
               fb_ok = 1'b0;
         end
      end
   endfunction
   sequence accepted_s; host_req_ack_out; endsequence
   sequence fallback_s; !outputs_live_out [*3]; endsequence
   sequence live_s; outputs_live_out [*3]; endsequence
   req_gate_a: assert property (
      accepted_s |-> host_req_valid_in && host_online_in && host_req_mode_in != `REQ_INVALID)
      else $error("ack without a valid online request");
   req_remote_a: assert property (accepted_s |=> switch_pos_out == `SW_REMOTE)
      else $error("ack away from remote position");
   req_target_a: assert property (accepted_s |-> ##2 mode_out == $past(tgt, 2))
      else $error("accepted request gave wrong mode");
   program_position_ignore_a: assert property (
      switch_pos_out == `SW_PROGRAM && $past(switch_pos_out, 2) == `SW_PROGRAM
      |-> !$past(host_req_ack_out, 2)) else $error("request taken at program position");
   run_lock_a: assert property (
      switch_pos_out == `SW_RUN && $past(switch_pos_out, 2) == `SW_RUN
      |-> !$past(host_req_ack_out, 2) && !download_permit_out && mode_out == `MODE_RUN)
      else $error("run position not locked");
   run_remote_a: assert property (
      switch_pos_out == `SW_REMOTE && $past(switch_pos_out) == `SW_RUN
      |=> mode_out == `MODE_REM_RUN) else $error("run to remote not remote run");
   program_position_remote_a: assert property (
      switch_pos_out == `SW_REMOTE && $past(switch_pos_out) == `SW_PROGRAM
      |=> mode_out == `MODE_REM_PROGRAM_POSITION) else $error("program to remote not remote program");
   test_entry_a: assert property (
      mode_out == `MODE_REM_TEST && $past(mode_out) != `MODE_REM_TEST
      |-> $past(host_req_ack_out, 2) && $past(host_req_mode_in, 2) == `REQ_REM_TEST)
      else $error("remote test entered without request");
   debounce_hold_a: assert property (
      switch_pos_out != $past(switch_pos_out) && $past(switch_pos_out) != `SW_INVALID
      |-> still_r >= DEB_CYCLES) else $error("position changed before debounce");
   fallback_drive_a: assert property (
      fallback_s |-> fb_ok($past(fallback_cfg_in), out_drive_out))
      else $error("fallback drive wrong");
   live_drive_a: assert property (
      live_s |-> out_drive_out == $past(logic_out_in)) else $error("live drive wrong");
   test_flags_a: assert property (
      mode_out == `MODE_REM_TEST && $past(mode_out) == `MODE_REM_TEST
      |-> task_exec_out && !outputs_live_out && !download_permit_out)
      else $error("remote test flags wrong");
   stop_flags_a: assert property (
      (mode_out == `MODE_REM_PROGRAM_POSITION || mode_out == `MODE_PROGRAM) && $stable(mode_out)
      && !$past(srst_in) && !$past(srst_in, 2)
      |-> !task_exec_out && !outputs_live_out && download_permit_out)
      else $error("stopped mode flags wrong");
endmodule
bind controller_mode_fsm mode_fsm_chk #(.DEB_CYCLES(DEB_CYCLES)) u_chk (
   .ref_clk_in(ref_clk_in), .srst_in(srst_in), .key_run_in(key_run_in),
   .key_remote_in(key_remote_in), .key_program_in(key_program_in),
   .host_online_in(host_online_in), .host_req_valid_in(host_req_valid_in),
   .host_req_mode_in(host_req_mode_in), .logic_out_in(logic_out_in),
   .fallback_cfg_in(fallback_cfg_in), .host_req_ack_out(host_req_ack_out),
   .mode_out(mode_out), .switch_pos_out(switch_pos_out), .task_exec_out(task_exec_out),
   .outputs_live_out(outputs_live_out), .download_permit_out(download_permit_out),
   .out_drive_out(out_drive_out));

/* key_switch_model.sv */
// Purpose: Front-panel key switch contacts for the mode logic
// Assumes: Position code 0 run, 1 remote, 2 program
// Notes: Short input closes the run contact as well (invalid)
`timescale 1ns/1ps
module key_switch_model (
   input wire [1:0] pos_in,
   input wire short_in,
   output wire run_out,
   output wire remote_out,
   output wire program_out
);
   assign run_out = (pos_in == 2'h0) || short_in;
   assign remote_out = pos_in == 2'h1;
   assign program_out = pos_in == 2'h2;
endmodule

/* mode_defines.vh */
// Purpose: Constants for the controller operating-mode logic
// Assumes: Included by the mode logic files
// Notes: Contact patterns are one-hot per position sampled from the key
`ifndef MODE_DEFINES_VH
`define MODE_DEFINES_VH

// Key switch position codes
`define SW_RUN 2'h0
`define SW_REMOTE 2'h1
`define SW_PROGRAM 2'h2
`define SW_INVALID 2'h3

// Contact patterns {program, remote, run}
`define KEYS_RUN 3'h1
`define KEYS_REMOTE 3'h2
`define KEYS_PROGRAM 3'h4

// Operating mode codes
`define MODE_RUN 3'h0
`define MODE_REM_RUN 3'h1
`define MODE_REM_PROGRAM_POSITION 3'h2
`define MODE_REM_TEST 3'h3
`define MODE_PROGRAM 3'h4

// Host request codes
`define REQ_REM_PROGRAM_POSITION 2'h0
`define REQ_REM_RUN 2'h1
`define REQ_REM_TEST 2'h2
`define REQ_INVALID 2'h3

// Fallback choice per output module
`define FB_OFF 2'h0
`define FB_ON 2'h1
`define FB_HOLD 2'h2

// Debounce time and count at 125 MHz
`define DEBOUNCE_CYCLES 17'h1e848
`define DEB_CNT_W 17

// Number of output modules
`define NUM_OUT 8

`endif

/* switch_debounce.v */
// Purpose: Synchronise and debounce the three-position key switch
// Assumes: Switch contacts are asynchronous to ref_clk_in
// Notes: Position reported only after it has held steady the full time
`timescale 1ns/1ps
`include "mode_defines.vh"

module switch_debounce #(
   parameter [`DEB_CNT_W-1:0] DEB_CYCLES = `DEBOUNCE_CYCLES
) (
   input wire ref_clk_in,
   input wire srst_in,
   input wire key_run_in,
   input wire key_remote_in,
   input wire key_program_in,
   output reg [1:0] pos_out,
   output reg pos_valid_out,
   output reg pos_change_out
);

   reg [2:0] meta_r;
   reg [2:0] sync_r;
   reg [1:0] cand_r;
   reg [`DEB_CNT_W-1:0] cnt_r;
   reg [1:0] raw_pos;

   // Encode sampled contacts
   always @* begin
      if (sync_r == `KEYS_RUN)
         raw_pos = `SW_RUN;
      else if (sync_r == `KEYS_REMOTE)
         raw_pos = `SW_REMOTE;
      else if (sync_r == `KEYS_PROGRAM)
         raw_pos = `SW_PROGRAM;
      else
         raw_pos = `SW_INVALID;
   end

   // [RULE15] Two-stage sync then debounce
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
         cand_r <= `SW_INVALID;
         cnt_r <= {`DEB_CNT_W{1'b0}};
         pos_out <= `SW_INVALID;
         pos_valid_out <= 1'b0;
         pos_change_out <= 1'b0;
      end else begin
         meta_r <= {key_program_in, key_remote_in, key_run_in};
         sync_r <= meta_r;
         pos_change_out <= 1'b0;
         if (raw_pos != cand_r) begin
            cand_r <= raw_pos;
            cnt_r <= {`DEB_CNT_W{1'b0}};
         end else if (cnt_r < DEB_CYCLES) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (raw_pos != `SW_INVALID && (raw_pos != pos_out || !pos_valid_out)) begin
            pos_out <= raw_pos;
            pos_valid_out <= 1'b1;
            pos_change_out <= 1'b1;
         end
      end
   end

endmodule

/* tb_controller_mode_fsm.sv */
// Purpose: Self-checking bench for the mode state machine
// Assumes: Debounce shortened to 4 cycles
// Notes: Mode and flags modelled from the switch and request history
`timescale 1ns/1ps
module tb_controller_mode_fsm;
   reg ref_clk_in, srst_in, host_online_in, host_req_valid_in, short_sw;
   reg [1:0] host_req_mode_in, pos_sw, exp_pos;
   reg [7:0] logic_out_in, held;
   reg [15:0] fallback_cfg_in;
   reg [2:0] exp_mode;
   reg [31:0] rnd;
   wire k_run, k_rem, k_program_position, ack, nak, tsk, live, edt, dl, fw, hp, msg, peer, net;
   wire [2:0] mode_out;
   wire [1:0] switch_pos_out;
   wire [7:0] out_drive_out;
   integer err_total, cmp_count, i;
   key_switch_model u_key (.pos_in(pos_sw), .short_in(short_sw), .run_out(k_run),
      .remote_out(k_rem), .program_out(k_program_position));
   controller_mode_fsm #(.DEB_CYCLES(4)) u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .key_run_in(k_run), .key_remote_in(k_rem), .key_program_in(k_program_position),
      .host_online_in(host_online_in), .host_req_valid_in(host_req_valid_in),
      .host_req_mode_in(host_req_mode_in), .logic_out_in(logic_out_in),
      .fallback_cfg_in(fallback_cfg_in), .host_req_ack_out(ack), .host_req_nak_out(nak),
      .mode_out(mode_out), .switch_pos_out(switch_pos_out), .task_exec_out(tsk),
      .outputs_live_out(live), .edit_permit_out(edt), .download_permit_out(dl),
      .fw_update_permit_out(fw), .host_mode_permit_out(hp), .msg_send_permit_out(msg),
      .peer_data_permit_out(peer), .net_sched_permit_out(net), .out_drive_out(out_drive_out));
   function [31:0] lfsr_next(input [31:0] s);
      lfsr_next = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   // Flags: task, live, edit, download, firmware, message, peer, schedule
   function [7:0] flags(input [2:0] m);
      case (m)
         3'h0: flags = 8'hc6;
         3'h1: flags = 8'he6;
         3'h3: flags = 8'ha2;
         default: flags = 8'h3b;
      endcase
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("compares=%0d mismatches=%0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task check_all;
      reg [7:0] e;
      integer j;
      begin
         @(posedge ref_clk_in);
         logic_out_in <= rnd[7:0];
         fallback_cfg_in <= rnd[23:8];
         rnd = lfsr_next(rnd);
         repeat (4) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         if (flags(exp_mode) & 8'h40)
            held = logic_out_in;
         for (j = 0; j < 8; j = j + 1)
            e[j] = (fallback_cfg_in[2*j+:2] == 2'h1) ||
               (fallback_cfg_in[2*j+:2] == 2'h2 && held[j]);
         chk(mode_out, exp_mode);
         chk(switch_pos_out, exp_pos);
         chk({tsk, live, edt, dl, fw, msg, peer, net}, flags(exp_mode));
         chk(hp, host_online_in && exp_pos == 2'h1);
         chk(out_drive_out, (flags(exp_mode) & 8'h40) ? held : e);
      end
   endtask
   task check_reset;
      begin
         chk({mode_out, switch_pos_out, out_drive_out}, 13'h1300);
         chk({tsk, live, edt, dl, fw, msg, peer, net, hp}, 9'h000);
      end
   endtask
   task move(input [1:0] p);
      begin
         @(posedge ref_clk_in);
         pos_sw <= p;
         exp_pos = p;
         exp_mode = (p == 2'h0) ? 3'h0 : (p == 2'h2) ? 3'h4 : (exp_mode == 3'h0) ? 3'h1 : 3'h2;
         repeat (15) @(posedge ref_clk_in);
         check_all;
      end
   endtask
   task req(input [1:0] code, input ok);
      begin
         @(posedge ref_clk_in);
         host_req_valid_in <= 1'b1;
         host_req_mode_in <= code;
         @(negedge ref_clk_in);
         chk({ack, nak}, ok ? 2'h2 : 2'h1);
         @(posedge ref_clk_in);
         host_req_valid_in <= 1'b0;
         if (ok)
            exp_mode = (code == 2'h0) ? 3'h2 : (code == 2'h1) ? 3'h1 : 3'h3;
         check_all;
      end
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      repeat (5000) @(posedge ref_clk_in);
      err_total = err_total + 1;
      end_sim;
   end
   initial begin
      err_total = 0;
      cmp_count = 0;
      rnd = 32'h0001553b;
      srst_in = 1'b1;
      host_online_in = 1'b1;
      host_req_valid_in = 1'b0;
      host_req_mode_in = 2'h0;
      logic_out_in = 8'h00;
      fallback_cfg_in = 16'h0000;
      pos_sw = 2'h0;
      short_sw = 1'b0;
      repeat (5) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      held = 8'h00;
      @(negedge ref_clk_in);
      check_reset;
      exp_mode = 3'h4;
      exp_pos = 2'h3;
      move(2'h0);
      req(2'h1, 1'b0);
      move(2'h1);
      for (i = 0; i < 4; i = i + 1)
         req(i[1:0], i != 3);
      @(posedge ref_clk_in);
      host_online_in <= 1'b0;
      req(2'h0, 1'b0);
      @(posedge ref_clk_in);
      host_online_in <= 1'b1;
      pos_sw <= 2'h2;
      repeat (2) @(posedge ref_clk_in);
      pos_sw <= 2'h1;
      short_sw <= 1'b1;
      repeat (20) @(posedge ref_clk_in);
      short_sw <= 1'b0;
      check_all;
      move(2'h2);
      req(2'h1, 1'b0);
      move(2'h1);
      move(2'h0);
      move(2'h1);
      req(2'h1, 1'b1);
      @(posedge ref_clk_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      held = 8'h00;
      @(negedge ref_clk_in);
      check_reset;
      exp_mode = 3'h4;
      exp_pos = 2'h3;
      req(2'h1, 1'b0);
      move(2'h1);
      end_sim;
   end
endmodule
